// *** flash_wp_pkg.sv ***
package flash_wp_pkg;

  // status word bit positions, low byte then high byte
  localparam int STATUS_W       = 16;
  localparam int BYTE_W         = 8;
  localparam int POS_BUSY       = 0;
  localparam int POS_WEL        = 1;
  localparam int POS_BP_LO      = 2;
  localparam int POS_BP_HI      = 4;
  localparam int POS_TB         = 5;
  localparam int POS_SEC        = 6;
  localparam int POS_LOCK_LOW   = 7;
  localparam int POS_LOCK_HIGH  = 8;
  localparam int POS_QUAD       = 9;

  // the non-volatile image covers status bits POS_BP_LO..POS_QUAD
  localparam int NV_LSB         = POS_BP_LO;
  localparam int NV_W           = POS_QUAD - NV_LSB + 1;
  localparam int NV_BP_LO       = POS_BP_LO - NV_LSB;
  localparam int NV_BP_HI       = POS_BP_HI - NV_LSB;
  localparam int NV_TB          = POS_TB - NV_LSB;
  localparam int NV_SEC         = POS_SEC - NV_LSB;
  localparam int NV_LOCK_LOW    = POS_LOCK_LOW - NV_LSB;
  localparam int NV_LOCK_HIGH   = POS_LOCK_HIGH - NV_LSB;
  localparam int NV_QUAD        = POS_QUAD - NV_LSB;
  localparam int NV_LOW_TOP     = BYTE_W - 1 - NV_LSB;
  localparam logic [NV_W-1:0] NV_FACTORY_DEFAULT = 8'h00;

  // status lock modes as {status_lock_high, status_lock_low}
  localparam logic [1:0] LOCK_SOFTWARE = 2'h0;
  localparam logic [1:0] LOCK_HARDWARE = 2'h1;
  localparam logic [1:0] LOCK_POWER    = 2'h2;
  localparam logic [1:0] LOCK_FOREVER  = 2'h3;

  // protect field codes
  localparam int BP_W                 = 3;
  localparam logic [2:0] BP_NONE      = 3'h0;
  localparam logic [2:0] BP_FULL      = 3'h7;
  localparam logic [2:0] BP_SEC_CAP   = 3'h4;
  localparam logic [2:0] BP_SEC_WIDE  = 3'h6;

  // region sizes as log2 of bytes
  localparam int ADDR_W         = 24;
  localparam int MBIT_LOG2      = 17;
  localparam int PAGE_LOG2      = 8;
  localparam int SECTOR_LOG2    = 12;
  localparam int HALF_BLK_LOG2  = 15;
  localparam int BLOCK_LOG2     = 16;
  localparam int DENSITY_DEF    = 32;

  typedef enum logic [3:0] {
    CMD_IDLE,
    CMD_WRITE_ENABLE,
    CMD_WRITE_DISABLE,
    CMD_WRITE_STATUS,
    CMD_PAGE_PROGRAM,
    CMD_QUAD_PAGE_PROGRAM,
    CMD_SECTOR_ERASE,
    CMD_BLOCK_ERASE_32,
    CMD_BLOCK_ERASE_64,
    CMD_CHIP_ERASE,
    CMD_QUAD_READ
  } cmd_type;

endpackage

// *** nv_status_store.sv ***
`timescale 1ns/1ps
module nv_status_store
  import flash_wp_pkg::*;
(
  input  wire logic            clk_sys,
  input  wire logic            srst,
  input  wire logic            power_cycle,
  input  wire logic            wr_en,
  input  wire logic [NV_W-1:0] wr_data,
  output logic      [NV_W-1:0] rd_data
);

  logic [NV_W-1:0] cells;

  // srst stands for a factory-fresh part; power_cycle keeps the cells but clears a power-mode lock
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cells <= NV_FACTORY_DEFAULT;
    end else if (power_cycle) begin
      // a power loss aborts any write in flight
      if ({cells[NV_LOCK_HIGH], cells[NV_LOCK_LOW]} == LOCK_POWER) begin
        cells[NV_LOCK_HIGH] <= 1'b0;
        cells[NV_LOCK_LOW]  <= 1'b0;
      end
    end else if (wr_en) begin
      cells <= wr_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rd_data <= NV_FACTORY_DEFAULT;
    end else begin
      rd_data <= cells;
    end
  end

endmodule

// *** flash_status_write_protect.sv ***
`timescale 1ns/1ps
module flash_status_write_protect
  import flash_wp_pkg::*;
#(
  parameter int DENSITY_MBIT = DENSITY_DEF
)
(
  input  wire logic              clk_sys,
  input  wire logic              srst,
  input  wire logic              power_cycle,
  input  wire logic              wp_pin,
  input  wire logic              cmd_valid,
  input  wire cmd_type           cmd_code,
  input  wire logic [ADDR_W-1:0] cmd_addr,
  input  wire logic [STATUS_W-1:0] cmd_status_data,
  input  wire logic              cmd_status_two_bytes,
  output logic [BYTE_W-1:0]      status_low_byte,
  output logic [BYTE_W-1:0]      status_high_byte,
  output logic                   write_enable_latch,
  output logic                   quad_lane_enable,
  output logic                   wp_hold_function_active,
  output logic                   cmd_done,
  output logic                   cmd_accepted,
  output logic                   cmd_refused,
  output logic                   array_go,
  output cmd_type                array_op,
  output logic [ADDR_W-1:0]      array_addr,
  output logic                   prot_none,
  output logic [ADDR_W-1:0]      prot_low,
  output logic [ADDR_W-1:0]      prot_high
);

  localparam int ARRAY_LOG2 = $clog2(DENSITY_MBIT) + MBIT_LOG2;
  localparam logic [ADDR_W-1:0] ARRAY_TOP =
    ADDR_W'((32'h1 << ARRAY_LOG2) - 32'h1);

  // ---------------------------------------------------------------
  // protect pin synchroniser: stage one feeds stage two only
  // ---------------------------------------------------------------
  logic wp_meta;
  logic wp_s2;
  logic wp_s3;
  logic wp_level;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wp_meta <= 1'b0;
      wp_s2   <= 1'b0;
      wp_s3   <= 1'b0;
    end else begin
      wp_meta <= wp_pin;
      wp_s2   <= wp_meta;
      wp_s3   <= wp_s2;
    end
  end

  // reset low is the safe side: a locked register until the pin is seen
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wp_level <= 1'b0;
    end else if (wp_s2 == wp_s3) begin
      wp_level <= wp_s3;
    end
  end

  // ---------------------------------------------------------------
  // non-volatile image
  // ---------------------------------------------------------------
  logic            nv_wr_en;
  logic [NV_W-1:0] nv_wr_data;
  logic [NV_W-1:0] nv_rd;

  nv_status_store u_nv (
    .clk_sys     (clk_sys),
    .srst        (srst),
    .power_cycle (power_cycle),
    .wr_en       (nv_wr_en),
    .wr_data     (nv_wr_data),
    .rd_data     (nv_rd)
  );

  logic [BP_W-1:0] protect_field;
  logic            top_bottom_select;
  logic            sector_granularity_select;
  logic            status_lock_low;
  logic            status_lock_high;
  logic            quad_bit;
  logic [1:0]      lock_mode;

  assign protect_field             = nv_rd[NV_BP_HI:NV_BP_LO];
  assign top_bottom_select         = nv_rd[NV_TB];
  assign sector_granularity_select = nv_rd[NV_SEC];
  assign status_lock_low           = nv_rd[NV_LOCK_LOW];
  assign status_lock_high          = nv_rd[NV_LOCK_HIGH];
  assign quad_bit                  = nv_rd[NV_QUAD];
  assign lock_mode = {status_lock_high, status_lock_low};

  // ---------------------------------------------------------------
  // protected range decode
  // ---------------------------------------------------------------
  logic        next_prot_none;
  logic [31:0] region_log2;
  logic [31:0] region_size;
  logic [31:0] next_prot_low;
  logic [31:0] next_prot_high;

  always_comb begin
    next_prot_none = 1'b0;
    region_log2    = 32'(ARRAY_LOG2);
    if (protect_field == BP_NONE) begin
      next_prot_none = 1'b1;
    end else if (protect_field == BP_FULL) begin
      region_log2 = 32'(ARRAY_LOG2);
    end else if (sector_granularity_select) begin
      // sector mode carves the end block only, but code 6 at 16 Mbit or less takes the whole array
      if (protect_field < BP_SEC_CAP) begin
        region_log2 = 32'(SECTOR_LOG2) + 32'(protect_field) - 32'h1;
      end else if (protect_field < BP_SEC_WIDE ||
                   ARRAY_LOG2 > BLOCK_LOG2 + 5) begin
        region_log2 = 32'(HALF_BLK_LOG2);
      end else begin
        region_log2 = 32'(ARRAY_LOG2);
      end
    end else begin
      // each code step doubles the count of 64KB blocks
      region_log2 = 32'(BLOCK_LOG2) + 32'(protect_field) - 32'h1;
      if (region_log2 > 32'(ARRAY_LOG2)) begin
        region_log2 = 32'(ARRAY_LOG2);
      end
    end
    region_size = 32'h1 << region_log2;
    if (top_bottom_select) begin
      next_prot_low  = 32'h0;
      next_prot_high = region_size - 32'h1;
    end else begin
      next_prot_low  = 32'(ARRAY_TOP) + 32'h1 - region_size;
      next_prot_high = 32'(ARRAY_TOP);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      prot_none <= 1'b1;
      prot_low  <= '0;
      prot_high <= '0;
    end else begin
      prot_none <= next_prot_none;
      prot_low  <= next_prot_low[ADDR_W-1:0];
      prot_high <= next_prot_high[ADDR_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // target region of a program or erase
  // ---------------------------------------------------------------
  logic [31:0] span_log2;
  logic [31:0] span_mask;
  logic [31:0] target_base;
  logic [31:0] target_end;
  logic        target_hit;
  logic        is_array_cmd;

  always_comb begin
    is_array_cmd = 1'b1;
    span_log2    = 32'(PAGE_LOG2);
    unique case (cmd_code)
      CMD_PAGE_PROGRAM,
      CMD_QUAD_PAGE_PROGRAM: span_log2 = 32'(PAGE_LOG2);
      CMD_SECTOR_ERASE:      span_log2 = 32'(SECTOR_LOG2);
      CMD_BLOCK_ERASE_32:    span_log2 = 32'(HALF_BLK_LOG2);
      CMD_BLOCK_ERASE_64:    span_log2 = 32'(BLOCK_LOG2);
      CMD_CHIP_ERASE:        span_log2 = 32'(ARRAY_LOG2);
      CMD_IDLE,
      CMD_WRITE_ENABLE,
      CMD_WRITE_DISABLE,
      CMD_WRITE_STATUS,
      CMD_QUAD_READ:         is_array_cmd = 1'b0;
    endcase
    span_mask   = (32'h1 << span_log2) - 32'h1;
    // addresses past the array wrap, as the array decoder does
    target_base = (32'(cmd_addr) & 32'(ARRAY_TOP)) & ~span_mask;
    target_end  = target_base | span_mask;
    // overlap test, using the range held one cycle earlier
    target_hit  = !prot_none &&
                  target_base <= 32'(prot_high) &&
                  target_end  >= 32'(prot_low);
  end

  // ---------------------------------------------------------------
  // status write permission and merge
  // ---------------------------------------------------------------
  logic hw_protect_live;
  logic status_write_ok;

  // with the quad bit set the protect pin is a data lane, so no gate
  assign hw_protect_live = !quad_bit;

  always_comb begin
    status_write_ok = 1'b0;
    unique case (lock_mode)
      LOCK_SOFTWARE: status_write_ok = write_enable_latch;
      LOCK_HARDWARE: status_write_ok = write_enable_latch &&
                       (wp_level || !hw_protect_live);
      LOCK_POWER:    status_write_ok = 1'b0;
      LOCK_FOREVER:  status_write_ok = 1'b0;
    endcase
  end

  always_comb begin
    nv_wr_data = nv_rd;
    if (cmd_status_two_bytes) begin
      nv_wr_data = cmd_status_data[POS_QUAD:NV_LSB];
    end else begin
      // one-byte write leaves the high byte as it was
      nv_wr_data[NV_LOW_TOP:0] = cmd_status_data[BYTE_W-1:NV_LSB];
    end
  end

  // only the status write path reaches the image
  assign nv_wr_en = cmd_valid && !power_cycle &&
                    cmd_code == CMD_WRITE_STATUS && status_write_ok;

  // ---------------------------------------------------------------
  // command outcome
  // ---------------------------------------------------------------
  logic next_accept;
  logic next_array_go;

  always_comb begin
    next_accept   = 1'b0;
    next_array_go = 1'b0;
    unique case (cmd_code)
      CMD_WRITE_ENABLE,
      CMD_WRITE_DISABLE:     next_accept = 1'b1;
      CMD_WRITE_STATUS:      next_accept = status_write_ok;
      CMD_QUAD_READ:         next_accept = quad_bit;
      CMD_QUAD_PAGE_PROGRAM: begin
        next_accept = quad_bit && write_enable_latch && !target_hit;
      end
      CMD_PAGE_PROGRAM,
      CMD_SECTOR_ERASE,
      CMD_BLOCK_ERASE_32,
      CMD_BLOCK_ERASE_64,
      CMD_CHIP_ERASE: begin
        // a host that skipped write-enable is refused here
        next_accept = write_enable_latch && !target_hit;
      end
      CMD_IDLE:              next_accept = 1'b0;
    endcase
    next_array_go = next_accept && is_array_cmd;
  end

  always_ff @(posedge clk_sys) begin
    if (srst || power_cycle) begin
      write_enable_latch <= 1'b0;
    end else if (cmd_valid) begin
      unique case (cmd_code)
        CMD_WRITE_ENABLE:  write_enable_latch <= 1'b1;
        CMD_WRITE_DISABLE,
        CMD_WRITE_STATUS,
        CMD_PAGE_PROGRAM,
        CMD_QUAD_PAGE_PROGRAM,
        CMD_SECTOR_ERASE,
        CMD_BLOCK_ERASE_32,
        CMD_BLOCK_ERASE_64,
        CMD_CHIP_ERASE:    write_enable_latch <= 1'b0;
        CMD_IDLE,
        CMD_QUAD_READ:     write_enable_latch <= write_enable_latch;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst || power_cycle) begin
      cmd_done     <= 1'b0;
      cmd_accepted <= 1'b0;
      cmd_refused  <= 1'b0;
    end else begin
      cmd_done     <= cmd_valid;
      cmd_accepted <= cmd_valid && next_accept;
      cmd_refused  <= cmd_valid && !next_accept;
    end
  end

  // the array sequencer sees only grants; refused targets never reach it
  always_ff @(posedge clk_sys) begin
    if (srst || power_cycle) begin
      array_go   <= 1'b0;
      array_op   <= CMD_IDLE;
      array_addr <= '0;
    end else begin
      array_go <= cmd_valid && next_array_go;
      if (cmd_valid && next_array_go) begin
        array_op   <= cmd_code;
        array_addr <= cmd_addr;
      end
    end
  end

  // ---------------------------------------------------------------
  // status read-back
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      status_low_byte  <= '0;
      status_high_byte <= '0;
    end else begin
      status_low_byte  <= '0;
      status_high_byte <= '0;
      status_low_byte[POS_WEL] <= write_enable_latch;
      status_low_byte[POS_BP_HI:POS_BP_LO] <= protect_field;
      status_low_byte[POS_TB]  <= top_bottom_select;
      status_low_byte[POS_SEC] <= sector_granularity_select;
      status_low_byte[POS_LOCK_LOW] <= status_lock_low;
      status_high_byte[POS_LOCK_HIGH-BYTE_W] <= status_lock_high;
      status_high_byte[POS_QUAD-BYTE_W]      <= quad_bit;
    end
  end

  // pin role: protect/hold functions, or data_lane_two/data_lane_three
  // a host strapping those pins must keep the quad bit clear
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      quad_lane_enable        <= 1'b0;
      wp_hold_function_active <= 1'b1;
    end else begin
      quad_lane_enable        <= quad_bit;
      wp_hold_function_active <= !quad_bit;
    end
  end

endmodule

// *** flash_wp_checker.sv ***
`timescale 1ns/1ps
module flash_wp_checker
  import flash_wp_pkg::*;
#(
  parameter int DENSITY_MBIT = DENSITY_DEF
)
(
  input wire logic              clk_sys,
  input wire logic              srst,
  input wire logic              power_cycle,
  input wire logic              cmd_valid,
  input wire cmd_type           cmd_code,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [BYTE_W-1:0] status_low_byte,
  input wire logic [BYTE_W-1:0] status_high_byte,
  input wire logic              write_enable_latch,
  input wire logic              quad_lane_enable,
  input wire logic              wp_hold_function_active,
  input wire logic              cmd_done,
  input wire logic              cmd_accepted,
  input wire logic              cmd_refused,
  input wire logic              array_go,
  input wire logic              prot_none,
  input wire logic [ADDR_W-1:0] prot_low,
  input wire logic [ADDR_W-1:0] prot_high
);
  logic [2:0]        quiet_age;
  logic              quiet;
  logic              take;
  logic [ADDR_W-1:0] tgt;

  // status outputs lag the cell by a few cycles; judge only settled state
  always_ff @(posedge clk_sys) begin
    if (srst || power_cycle || (cmd_valid && cmd_code == CMD_WRITE_STATUS))
      quiet_age <= 3'h0;
    else if (quiet_age != 3'h7)
      quiet_age <= quiet_age + 3'h1;
  end
  assign quiet = (quiet_age == 3'h7);
  assign take = cmd_valid && !power_cycle;
  assign tgt = cmd_addr & ADDR_W'((DENSITY_MBIT << MBIT_LOG2) - 1);

  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);

  chk_done_follows: assert property (take |=> cmd_done)
    else $error("command without done pulse");
  chk_single_verdict: assert property (cmd_done |-> cmd_accepted ^ cmd_refused)
    else $error("done without exactly one verdict");
  chk_latch_set: assert property (
    take && cmd_code == CMD_WRITE_ENABLE |=> write_enable_latch)
    else $error("latch not set");
  chk_latch_clear: assert property (
    take && cmd_code inside {CMD_WRITE_DISABLE, CMD_WRITE_STATUS,
    CMD_PAGE_PROGRAM, CMD_SECTOR_ERASE, CMD_BLOCK_ERASE_32,
    CMD_BLOCK_ERASE_64, CMD_CHIP_ERASE} |=> !write_enable_latch)
    else $error("latch not cleared");
  chk_latch_shown: assert property (
    status_low_byte[POS_WEL] == $past(write_enable_latch))
    else $error("status bit one differs from latch");
  chk_needs_latch: assert property (
    take && cmd_code == CMD_WRITE_STATUS && !write_enable_latch
    |=> cmd_refused)
    else $error("status write accepted without latch");
  chk_power_lock: assert property (
    take && quiet && status_high_byte[0] && !status_low_byte[7]
    && cmd_code == CMD_WRITE_STATUS |=> cmd_refused)
    else $error("write accepted in power lock");
  chk_power_restore: assert property (
    power_cycle && quiet && status_high_byte[0] && !status_low_byte[7]
    |-> ##[1:6] !status_high_byte[0])
    else $error("power cycle kept lock");
  chk_otp_lock: assert property (
    take && status_high_byte[0] && status_low_byte[7]
    && cmd_code == CMD_WRITE_STATUS |=> cmd_refused)
    else $error("write accepted in permanent lock");
  chk_quad_gate: assert property (
    take && quiet && !quad_lane_enable
    && cmd_code inside {CMD_QUAD_READ, CMD_QUAD_PAGE_PROGRAM}
    |=> cmd_refused)
    else $error("quad command accepted without quad bit");
  chk_quad_pins: assert property (
    quad_lane_enable != wp_hold_function_active)
    else $error("pin function disagrees with quad bit");
  chk_guard_range: assert property (
    take && quiet && cmd_code == CMD_SECTOR_ERASE && !prot_none
    && tgt >= prot_low && tgt <= prot_high |=> cmd_refused && !array_go)
    else $error("erase of protected sector granted");
  chk_grant_ok: assert property (array_go |-> cmd_accepted)
    else $error("array grant without acceptance");

  cover property (take && cmd_code == CMD_WRITE_ENABLE);
  cover property (array_go);
  cover property (cmd_refused);
  cover property (power_cycle && status_high_byte[0]);
endmodule

bind flash_status_write_protect flash_wp_checker #(
  .DENSITY_MBIT(DENSITY_MBIT)
) chk_inst (
  .clk_sys, .srst, .power_cycle, .cmd_valid, .cmd_code, .cmd_addr,
  .status_low_byte, .status_high_byte, .write_enable_latch,
  .quad_lane_enable, .wp_hold_function_active, .cmd_done, .cmd_accepted,
  .cmd_refused, .array_go, .prot_none, .prot_low, .prot_high
);

// *** flash_host_model.sv ***
`timescale 1ns/1ps
module flash_host_model
  import flash_wp_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              cmd_accepted,
  output logic                   cmd_valid,
  output cmd_type                cmd_code,
  output logic [ADDR_W-1:0]      cmd_addr,
  output logic [STATUS_W-1:0]    cmd_status_data,
  output logic                   cmd_status_two_bytes
);
  initial begin
    cmd_valid = 1'b0;
    cmd_code = CMD_IDLE;
    cmd_addr = '0;
    cmd_status_data = '0;
    cmd_status_two_bytes = 1'b1;
  end

  // callers put a write enable before program, erase, status write unless testing its absence
  task automatic send(input cmd_type c, input logic [ADDR_W-1:0] a,
                      input logic [STATUS_W-1:0] d, input logic two,
                      output logic ok);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_addr <= a;
    cmd_status_data <= d;
    cmd_status_two_bytes <= two;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    // released lines must not keep looking valid
    cmd_addr <= ~a;
    cmd_status_data <= ~d;
    // the verdict pulse stands only in the cycle after the taking edge
    #1;
    ok = cmd_accepted;
    // leave room for the status and range outputs to settle
    repeat (4) @(posedge clk_sys);
    #1;
  endtask
endmodule

// *** flash_status_write_protect_test.sv ***
`timescale 1ns/1ps
module flash_status_write_protect_test;
  import flash_wp_pkg::*;
  logic              clk_sys;
  logic              srst;
  logic              power_cycle;
  logic              wp_pin;
  logic              cmd_valid;
  cmd_type           cmd_code;
  logic [ADDR_W-1:0] cmd_addr;
  logic [15:0]       cmd_status_data;
  logic              cmd_status_two_bytes;
  logic [7:0]        status_low_byte;
  logic [7:0]        status_high_byte;
  logic              write_enable_latch;
  logic              quad_lane_enable;
  logic              wp_hold_function_active;
  logic              cmd_done;
  logic              cmd_accepted;
  logic              cmd_refused;
  logic              array_go;
  cmd_type           array_op;
  logic [ADDR_W-1:0] array_addr;
  logic              prot_none;
  logic [ADDR_W-1:0] prot_low;
  logic [ADDR_W-1:0] prot_high;
  logic              ok;
  logic [ADDR_W-1:0] sz;
  int                err_count;
  int                checks_done;

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  flash_status_write_protect #(.DENSITY_MBIT(32)) uut (
    .clk_sys, .srst, .power_cycle, .wp_pin, .cmd_valid, .cmd_code,
    .cmd_addr, .cmd_status_data, .cmd_status_two_bytes, .status_low_byte,
    .status_high_byte, .write_enable_latch, .quad_lane_enable,
    .wp_hold_function_active, .cmd_done, .cmd_accepted, .cmd_refused,
    .array_go, .array_op, .array_addr, .prot_none, .prot_low, .prot_high);

  flash_host_model host (
    .clk_sys, .cmd_accepted, .cmd_valid, .cmd_code, .cmd_addr,
    .cmd_status_data, .cmd_status_two_bytes);

  task automatic cmp_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_word(input logic [ADDR_W-1:0] got,
                          input logic [ADDR_W-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // protected bytes minus one at 32 Mbit
  function automatic logic [ADDR_W-1:0] span(input logic sec,
                                             input logic [2:0] bp);
    if (bp == BP_FULL) return 24'h3fffff;
    if (!sec) return (24'h010000 << (bp - 3'h1)) - 24'h000001;
    if (bp >= BP_SEC_CAP) return 24'h007fff;
    return (24'h001000 << (bp - 3'h1)) - 24'h000001;
  endfunction

  task automatic op(input cmd_type c, input logic [ADDR_W-1:0] a);
    host.send(c, a, '0, 1'b1, ok);
  endtask

  task automatic wr(input logic [15:0] d, input logic two);
    op(CMD_WRITE_ENABLE, '0);
    host.send(CMD_WRITE_STATUS, '0, d, two, ok);
  endtask

  task automatic pulse_power();
    // let the checker's settle counter run out so its lock checks arm
    repeat (4) @(posedge clk_sys);
    power_cycle <= 1'b1;
    @(posedge clk_sys);
    power_cycle <= 1'b0;
    repeat (5) @(posedge clk_sys);
    #1;
  endtask

  task automatic set_pin(input logic v);
    @(posedge clk_sys);
    wp_pin <= v;
    repeat (5) @(posedge clk_sys);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    wrap_up();
  end

  initial begin
    srst = 1'b1;
    power_cycle = 1'b0;
    wp_pin = 1'b1;
    err_count = 0;
    checks_done = 0;
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    cmp_word(ADDR_W'(status_low_byte), '0);
    cmp_word(ADDR_W'(status_high_byte), '0);
    cmp_bit(prot_none, 1'b1);
    cmp_bit(wp_hold_function_active, 1'b1);
    op(CMD_WRITE_ENABLE, '0);
    cmp_bit(write_enable_latch, 1'b1);
    cmp_bit(status_low_byte[POS_WEL], 1'b1);
    op(CMD_WRITE_DISABLE, '0);
    cmp_bit(write_enable_latch, 1'b0);
    host.send(CMD_WRITE_STATUS, '0, 16'h001c, 1'b1, ok);
    cmp_bit(ok, 1'b0);
    op(CMD_WRITE_ENABLE, '0);
    pulse_power();
    cmp_bit(write_enable_latch, 1'b0);
    // every protect code but BP_NONE in both granularities and from both ends
    for (int i = 1; i < 32; i++) begin
      if (i[2:0] != 3'h0) begin
        wr({9'h0, i[3], i[4], i[2:0], 2'h0}, 1'b1);
        sz = span(i[3], i[2:0]);
        cmp_word(ADDR_W'(status_low_byte), {i[3], i[4], i[2:0], 2'h0});
        cmp_bit(prot_none, 1'b0);
        cmp_word(prot_low, i[4] ? '0 : 24'h3fffff - sz);
        cmp_word(prot_high, i[4] ? sz : 24'h3fffff);
      end
    end
    wr(16'h0004, 1'b1);
    op(CMD_WRITE_ENABLE, '0);
    op(CMD_SECTOR_ERASE, 24'h3f0000);
    cmp_bit(ok, 1'b0);
    cmp_bit(write_enable_latch, 1'b0);
    op(CMD_WRITE_ENABLE, '0);
    op(CMD_SECTOR_ERASE, 24'h3ef000);
    cmp_bit(ok, 1'b1);
    cmp_word(array_addr, 24'h3ef000);
    cmp_word(ADDR_W'(array_op), ADDR_W'(CMD_SECTOR_ERASE));
    op(CMD_WRITE_ENABLE, '0);
    op(CMD_CHIP_ERASE, '0);
    cmp_bit(ok, 1'b0);
    op(CMD_WRITE_ENABLE, '0);
    op(CMD_BLOCK_ERASE_64, 24'h3e0000);
    cmp_bit(ok, 1'b1);
    op(CMD_WRITE_ENABLE, '0);
    op(CMD_BLOCK_ERASE_32, 24'h3f8000);
    cmp_bit(ok, 1'b0);
    op(CMD_PAGE_PROGRAM, 24'h000100);
    cmp_bit(ok, 1'b0);
    wr(16'h0000, 1'b1);
    cmp_bit(prot_none, 1'b1);
    op(CMD_QUAD_READ, '0);
    cmp_bit(ok, 1'b0);
    // the bench drives the pin, so it is never strapped here
    wr(16'h0200, 1'b1);
    cmp_bit(quad_lane_enable, 1'b1);
    cmp_bit(wp_hold_function_active, 1'b0);
    op(CMD_QUAD_READ, '0);
    cmp_bit(ok, 1'b1);
    op(CMD_WRITE_ENABLE, '0);
    op(CMD_QUAD_PAGE_PROGRAM, 24'h000100);
    cmp_bit(ok, 1'b1);
    cmp_bit(write_enable_latch, 1'b0);
    wr(16'h0000, 1'b0);
    cmp_word(ADDR_W'(status_high_byte), 24'h000002);
    wr(16'h0000, 1'b1);
    wr(16'h0080, 1'b1);
    cmp_bit(status_low_byte[7], 1'b1);
    set_pin(1'b0);
    wr(16'h00a0, 1'b1);
    cmp_bit(ok, 1'b0);
    cmp_bit(status_low_byte[POS_TB], 1'b0);
    set_pin(1'b1);
    wr(16'h0100, 1'b1);
    cmp_bit(ok, 1'b1);
    cmp_bit(status_high_byte[0], 1'b1);
    wr(16'h0000, 1'b1);
    cmp_bit(ok, 1'b0);
    pulse_power();
    cmp_bit(status_high_byte[0], 1'b0);
    wr(16'h0180, 1'b1);
    cmp_bit(ok, 1'b1);
    pulse_power();
    wr(16'h0000, 1'b1);
    cmp_bit(ok, 1'b0);
    cmp_bit(status_high_byte[0], 1'b1);
    wrap_up();
  end
endmodule
